// ### cts_capture.sv
// Five-channel input capture with three selectable 16-bit time bases
//
// Chosen here: the address-and-strobe port and the address map.
`default_nettype none
module cts_capture (
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  input  wire cts_pkg::cts_bus_req_type bus,
  input  wire logic [4:0]               capture_pin,
  input  wire logic                     sosc_pin,
  input  wire logic [2:0]               timer_ext_clock_pin,
  input  wire logic                     sleep_mode,
  output var  logic [7:0]               rd_data,
  output var  logic                     irq
);
  import cts_pkg::*;

  logic [15:0] tb_count   [CTS_TIMEBASES];
  logic        tb_ext     [CTS_TIMEBASES];
  logic [2:0]  tb_ctl     [CTS_TIMEBASES];
  logic [7:0]  ctrl       [CTS_CHANNELS];
  logic [15:0] cap_value  [CTS_CHANNELS];
  logic [1:0]  tb_sel     [CTS_CHANNELS];
  logic [4:0]  flag_vec;
  logic [4:0]  mask_reg;
  logic [4:0]  prio_reg;
  logic [1:0]  instr_div_reg;
  logic [2:0]  sosc_sync_reg;
  logic [7:0]  rd_data_reg;
  logic [7:0]  rd_mux;
  logic        irq_reg;

  // Instruction clock is the system clock divided by four
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      instr_div_reg <= 2'h0;
    end else begin
      instr_div_reg <= instr_div_reg + 2'h1;
    end
  end

  // Secondary oscillator: two-stage synchroniser, third stage for edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sosc_sync_reg <= 3'h0;
    end else begin
      sosc_sync_reg <= {sosc_sync_reg[1:0], sosc_pin};
    end
  end

  genvar t;
  generate
    for (t = 0; t < CTS_TIMEBASES; t++) begin : g_tb
      logic [2:0]  ext_sync_reg;
      logic [2:0]  tb_ctl_reg;
      logic [15:0] tb_count_reg;
      logic        tick;
      logic        wr_ctl;
      logic        wr_lo;
      logic        wr_hi;
      cts_src_type src;

      assign src    = cts_src_type'(tb_ctl_reg[CTS_TBCTL_SRC_LSB +: 2]);
      assign wr_ctl = bus.wr && bus.addr == CTS_OFF_TBCTL_BASE + 8'(t);
      assign wr_lo  = bus.wr && bus.addr == CTS_OFF_TBCNT_BASE + 8'(2 * t);
      assign wr_hi  = bus.wr && bus.addr == CTS_OFF_TBCNT_BASE + 8'(2 * t + 1);

      always_ff @(posedge ref_clk) begin
        if (srst) begin
          ext_sync_reg <= 3'h0;
        end else begin
          ext_sync_reg <= {ext_sync_reg[1:0], timer_ext_clock_pin[t]};
        end
      end

      always_ff @(posedge ref_clk) begin
        if (srst) begin
          tb_ctl_reg <= CTS_TBCTL_RESET;
        end else if (wr_ctl) begin
          tb_ctl_reg <= bus.wdata[2:0];
        end
      end

      // Fosc sources stop in sleep and simply hold; nothing reloads on wake
      always_comb begin
        unique case (src)
          CTS_SRC_FOSC:  tick = !sleep_mode; // R03
          CTS_SRC_INSTR: tick = !sleep_mode && instr_div_reg == CTS_INSTR_LAST; // R03
          CTS_SRC_SOSC:  tick = sosc_sync_reg[1] && !sosc_sync_reg[2]; // R02
          CTS_SRC_PIN:   tick = ext_sync_reg[1] && !ext_sync_reg[2]; // R02
        endcase
      end

      // Software write wins over an increment in the same cycle
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          tb_count_reg <= CTS_TBCNT_RESET;
        end else if (wr_lo) begin
          tb_count_reg[7:0] <= bus.wdata;
        end else if (wr_hi) begin
          tb_count_reg[15:8] <= bus.wdata;
        end else if (tb_ctl_reg[CTS_TBCTL_ON_BIT] && tick) begin
          tb_count_reg <= tb_count_reg + 16'h0001; // R01 R04
        end
      end

      assign tb_count[t] = tb_count_reg;
      assign tb_ctl[t]   = tb_ctl_reg;
      assign tb_ext[t]   = src == CTS_SRC_SOSC || src == CTS_SRC_PIN;
    end
  endgenerate

  // Timer select fields; unused bit positions are never stored
  logic [7:0] sel_a_reg;
  logic [3:0] sel_b_reg;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sel_a_reg <= 8'h00;
      sel_b_reg <= 4'h0;
    end else if (bus.wr && bus.addr == CTS_OFF_SEL_A) begin
      sel_a_reg <= bus.wdata & 8'hDB; // R06
    end else if (bus.wr && bus.addr == CTS_OFF_SEL_B) begin
      sel_b_reg <= bus.wdata[3:0]; // R06
    end
  end
  assign tb_sel[0] = sel_a_reg[CTS_SEL_C1_LSB +: 2];
  assign tb_sel[1] = sel_a_reg[CTS_SEL_C2_LSB +: 2];
  assign tb_sel[2] = sel_a_reg[CTS_SEL_C3_LSB +: 2];
  assign tb_sel[3] = sel_b_reg[CTS_SEL_C4_LSB +: 2];
  assign tb_sel[4] = sel_b_reg[CTS_SEL_C5_LSB +: 2];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mask_reg <= 5'h00;
      prio_reg <= 5'h00;
    end else if (bus.wr && bus.addr == CTS_OFF_ENABLE) begin
      mask_reg <= bus.wdata[4:0];
    end else if (bus.wr && bus.addr == CTS_OFF_PRIO) begin
      prio_reg <= bus.wdata[4:0];
    end
  end

  genvar c;
  generate
    for (c = 0; c < CTS_CHANNELS; c++) begin : g_ch
      localparam logic [7:0] WMASK = (c < CTS_FULL_CTRL_CHANNELS) ?
                                     CTS_CTRL_MASK_FULL : CTS_CTRL_MASK_SHORT;
      logic [2:0]  pin_sync_reg;
      logic [7:0]  ctrl_reg;
      logic [3:0]  presc_reg;
      logic [15:0] value_reg;
      logic        flag_reg;
      logic [1:0]  base;
      logic [3:0]  mode;
      logic        is_cap;
      logic        rise;
      logic        fall;
      logic        live;
      logic        hit;
      logic        wr_lo;
      logic        wr_hi;

      // Reserved select code 3 falls back to the first time base
      assign base   = (tb_sel[c] == 2'h3) ? 2'h0 : tb_sel[c];
      assign mode   = ctrl_reg[3:0];
      assign is_cap = mode[3:2] == CTS_MODE_CAP_TOP;
      assign rise   = pin_sync_reg[1] && !pin_sync_reg[2]; // R11
      assign fall   = !pin_sync_reg[1] && pin_sync_reg[2]; // R11
      // With its clock stopped a fosc-based channel cannot see edges
      assign live   = !sleep_mode || tb_ext[base]; // R05
      assign wr_lo  = bus.wr && bus.addr == CTS_OFF_VAL_BASE + 8'(2 * c);
      assign wr_hi  = bus.wr && bus.addr == CTS_OFF_VAL_BASE + 8'(2 * c + 1);

      always_ff @(posedge ref_clk) begin
        if (srst) begin
          pin_sync_reg <= 3'h0;
        end else begin
          pin_sync_reg <= {pin_sync_reg[1:0], capture_pin[c]}; // R11
        end
      end

      always_ff @(posedge ref_clk) begin
        if (srst) begin
          ctrl_reg <= CTS_CTRL_RESET;
        end else if (bus.wr && bus.addr == CTS_OFF_CTRL_BASE + 8'(c)) begin
          ctrl_reg <= bus.wdata & WMASK; // R06
        end
      end

      // Counts qualifying rising edges; a ratio change alone keeps it
      always_ff @(posedge ref_clk) begin
        if (srst || !is_cap) begin
          presc_reg <= 4'h0; // R10
        end else if (rise && live) begin
          presc_reg <= presc_reg + 4'h1;
        end
      end

      always_comb begin
        hit = 1'b0;
        if (is_cap && live) begin
          unique case (mode)
            CTS_MODE_FALL:   hit = fall; // R07
            CTS_MODE_RISE:   hit = rise; // R07
            CTS_MODE_RISE4:  hit = rise && presc_reg[1:0] == 2'h3; // R07
            CTS_MODE_RISE16: hit = rise && presc_reg == 4'hF; // R07
            default:         hit = 1'b0;
          endcase
        end
      end

      // A capture overwrites an unread value; it also beats a software write
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          value_reg <= CTS_VAL_RESET;
        end else if (hit) begin
          value_reg <= tb_count[base]; // R01 R08 R09
        end else if (wr_lo) begin
          value_reg[7:0] <= bus.wdata;
        end else if (wr_hi) begin
          value_reg[15:8] <= bus.wdata;
        end
      end

      // Set wins over a write-one clear in the same cycle
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          flag_reg <= 1'b0;
        end else if (hit) begin
          flag_reg <= 1'b1; // R09
        end else if (bus.wr && bus.addr == CTS_OFF_FLAG && bus.wdata[c]) begin
          flag_reg <= 1'b0; // R09
        end
      end

      assign ctrl[c]      = ctrl_reg;
      assign cap_value[c] = value_reg;
      assign flag_vec[c]  = flag_reg;
    end
  endgenerate

  always_comb begin
    rd_mux = 8'h00; // R06
    for (int i = 0; i < CTS_CHANNELS; i++) begin
      if (bus.addr == CTS_OFF_CTRL_BASE + 8'(i)) begin
        rd_mux = ctrl[i];
      end
      if (bus.addr == CTS_OFF_VAL_BASE + 8'(2 * i)) begin
        rd_mux = cap_value[i][7:0];
      end
      if (bus.addr == CTS_OFF_VAL_BASE + 8'(2 * i + 1)) begin
        rd_mux = cap_value[i][15:8];
      end
    end
    for (int j = 0; j < CTS_TIMEBASES; j++) begin
      if (bus.addr == CTS_OFF_TBCTL_BASE + 8'(j)) begin
        rd_mux = {5'h00, tb_ctl[j]};
      end
      if (bus.addr == CTS_OFF_TBCNT_BASE + 8'(2 * j)) begin
        rd_mux = tb_count[j][7:0];
      end
      if (bus.addr == CTS_OFF_TBCNT_BASE + 8'(2 * j + 1)) begin
        rd_mux = tb_count[j][15:8];
      end
    end
    if (bus.addr == CTS_OFF_SEL_A) begin
      rd_mux = sel_a_reg;
    end
    if (bus.addr == CTS_OFF_SEL_B) begin
      rd_mux = {4'h0, sel_b_reg};
    end
    if (bus.addr == CTS_OFF_PRIO) begin
      rd_mux = {3'h0, prio_reg};
    end
    if (bus.addr == CTS_OFF_ENABLE) begin
      rd_mux = {3'h0, mask_reg};
    end
    if (bus.addr == CTS_OFF_FLAG) begin
      rd_mux = {3'h0, flag_vec};
    end
  end

  // Read data only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_data_reg <= 8'h00;
    end else begin
      rd_data_reg <= bus.rd ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flag_vec & mask_reg);
    end
  end

  assign rd_data = rd_data_reg;
  assign irq     = irq_reg;

endmodule
`default_nettype wire

// ### cts_capture_assertions.sv
// Port-level checker for the capture time-base block
`default_nettype none
module cts_capture_assertions (
  input wire logic                     ref_clk,
  input wire logic                     srst,
  input wire cts_pkg::cts_bus_req_type bus,
  input wire logic [4:0]               capture_pin,
  input wire logic                     sosc_pin,
  input wire logic [2:0]               timer_ext_clock_pin,
  input wire logic                     sleep_mode,
  input wire logic [7:0]               rd_data,
  input wire logic                     irq
);
  timeunit 1ns;
  timeprecision 1ns;
  import cts_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [7:0] pin_hist_reg;
  // Pin activity history: besides software, the only cause for irq to rise
  always_ff @(posedge ref_clk) begin
    pin_hist_reg <= {pin_hist_reg[6:0], capture_pin != $past(capture_pin)};
  end
  sequence s_read_at(logic [7:0] lo, logic [7:0] hi);
    bus.rd && bus.addr >= lo && bus.addr <= hi;
  endsequence
  a_rd_idle_zero: assert property (!$past(bus.rd) |-> rd_data == 8'h00)
    else $error("read data without a read");
  a_ctrl_short_bits: assert property (s_read_at(8'h03, 8'h04) |=> rd_data[7:6] == 2'h0)
    else $error("absent control bits read nonzero");
  a_irq_bits_zero: assert property (
    s_read_at(CTS_OFF_PRIO, CTS_OFF_FLAG) |=> rd_data[7:5] == 3'h0)
    else $error("absent interrupt bits read nonzero");
  a_sel_gaps_zero: assert property (
    s_read_at(CTS_OFF_SEL_A, CTS_OFF_SEL_A) |=> !rd_data[5] && !rd_data[2])
    else $error("select gap bits read nonzero");
  a_unmapped_zero: assert property (s_read_at(8'h1D, 8'hFF) |=> rd_data == 8'h00)
    else $error("unmapped read nonzero");
  a_irq_rise_cause: assert property (
    $rose(irq) |-> $past(bus.wr) || $past(bus.wr, 2) || |pin_hist_reg[7:2])
    else $error("irq rose without cause");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(bus.wr, 2) || $past(srst))
    else $error("irq fell without software clear");
  a_reset_quiet: assert property ($fell(srst) |-> !irq && rd_data == 8'h00)
    else $error("outputs active after reset");
endmodule
bind cts_capture cts_capture_assertions cts_capture_assertions_inst (.ref_clk, .srst, .bus,
  .capture_pin, .sosc_pin, .timer_ext_clock_pin, .sleep_mode, .rd_data, .irq);
`default_nettype wire

// ### cts_capture_test.sv
// Self-checking bench for the capture time-base block
`default_nettype none
module cts_capture_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cts_pkg::*;
  logic            ref_clk, srst, sosc_pin, sleep_mode, irq;
  cts_bus_req_type bus;
  logic [4:0]      capture_pin;
  logic [2:0]      timer_ext_clock_pin;
  logic [7:0]      rd_data, v, w;
  int              n_errors, check_count;
  int              nrise[4] = '{1, 1, 4, 16};
  cts_capture cts_capture_inst (.ref_clk, .srst, .bus, .capture_pin, .sosc_pin,
    .timer_ext_clock_pin, .sleep_mode, .rd_data, .irq);
  cts_pin_model cts_pin_model_inst (.ref_clk, .capture_pin, .sosc_pin, .timer_ext_clock_pin);
  task automatic chk(input logic [7:0] got, input logic [7:0] e);
    check_count++;
    if (got !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk) bus.rd <= 1'b0;
    #1 v = rd_data;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk) bus.wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(v, e);
  endtask
  task automatic wrc(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    wr(a, d);
    rdc(a, e);
  endtask
  task automatic pl(input int k, input int n);
    cts_pin_model_inst.edges(k, n);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Whole run is under a thousand cycles
  initial begin
    #500000;
    n_errors++;
    end_sim();
  end
  initial begin
    srst = 1'b1;
    sleep_mode = 1'b0;
    bus = '0;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    for (int a = 0; a < 32; a++) rdc(8'(a), 8'h00);
    rdc(8'hFF, 8'h00);
    wrc(CTS_OFF_CTRL_BASE, 8'hFF, 8'hFF);
    wrc(CTS_OFF_CTRL_BASE + 8'h4, 8'hFF, 8'h3F);
    wrc(CTS_OFF_SEL_A, 8'hFF, 8'hDB);
    wrc(CTS_OFF_SEL_B, 8'hFF, 8'h0F);
    wrc(CTS_OFF_PRIO, 8'hFF, 8'h1F);
    wrc(CTS_OFF_VAL_BASE + 8'h9, 8'hA5, 8'hA5);
    wrc(CTS_OFF_TBCTL_BASE, 8'hFF, 8'h07);
    wr(CTS_OFF_CTRL_BASE + 8'h4, 8'h00);
    wr(CTS_OFF_SEL_A, 8'h00);
    wr(CTS_OFF_SEL_B, 8'h00);
    $display("register access test done");
    wr(CTS_OFF_TBCNT_BASE, 8'h34);
    wr(CTS_OFF_TBCNT_BASE + 8'h1, 8'h12);
    wr(CTS_OFF_ENABLE, 8'h1F);
    wr(CTS_OFF_CTRL_BASE, {4'h0, CTS_MODE_RISE});
    pl(0, 2);
    rdc(CTS_OFF_VAL_BASE, 8'h34);
    rdc(CTS_OFF_VAL_BASE + 8'h1, 8'h12);
    rdc(CTS_OFF_FLAG, 8'h01);
    chk({7'h0, irq}, 8'h01);
    pl(5, 10);
    rdc(CTS_OFF_TBCNT_BASE, 8'h39);
    wr(CTS_OFF_VAL_BASE, 8'hEE);
    pl(0, 2);
    rdc(CTS_OFF_VAL_BASE, 8'h39);
    wr(CTS_OFF_FLAG, 8'h01);
    rdc(CTS_OFF_FLAG, 8'h00);
    chk({7'h0, irq}, 8'h00);
    $display("capture test done");
    for (int m = 0; m < 4; m++) begin
      wr(CTS_OFF_CTRL_BASE, 8'h00);
      wr(CTS_OFF_FLAG, 8'h01);
      wr(CTS_OFF_CTRL_BASE, {4'h0, CTS_MODE_FALL + 4'(m)});
      pl(0, 2 * nrise[m] - 2);
      rdc(CTS_OFF_FLAG, 8'h00);
      pl(0, 1);
      rdc(CTS_OFF_FLAG, {7'h0, m != 0});
      pl(0, 1);
      rdc(CTS_OFF_FLAG, 8'h01);
    end
    // Ratio change keeps the edge count, leaving capture mode drops it
    wr(CTS_OFF_CTRL_BASE, 8'h00);
    wr(CTS_OFF_FLAG, 8'h01);
    wr(CTS_OFF_CTRL_BASE, {4'h0, CTS_MODE_RISE4});
    pl(0, 4);
    wr(CTS_OFF_CTRL_BASE, {4'h0, CTS_MODE_RISE16});
    pl(0, 26);
    rdc(CTS_OFF_FLAG, 8'h00);
    pl(0, 2);
    rdc(CTS_OFF_FLAG, 8'h01);
    wr(CTS_OFF_CTRL_BASE, 8'h00);
    wr(CTS_OFF_CTRL_BASE, {4'h0, CTS_MODE_RISE4});
    pl(0, 4);
    wr(CTS_OFF_CTRL_BASE, 8'h02);
    wr(CTS_OFF_FLAG, 8'h01);
    wr(CTS_OFF_CTRL_BASE, {4'h0, CTS_MODE_RISE4});
    pl(0, 6);
    rdc(CTS_OFF_FLAG, 8'h00);
    pl(0, 2);
    rdc(CTS_OFF_FLAG, 8'h01);
    $display("mode and prescaler test done");
    wr(CTS_OFF_CTRL_BASE, {4'h0, CTS_MODE_RISE});
    wr(CTS_OFF_FLAG, 8'h1F);
    wr(CTS_OFF_TBCTL_BASE, 8'h04);
    @(posedge ref_clk) sleep_mode <= 1'b1;
    wr(CTS_OFF_TBCNT_BASE + 8'h1, 8'h80);
    wr(CTS_OFF_TBCNT_BASE, 8'h00);
    pl(0, 2);
    rdc(CTS_OFF_FLAG, 8'h00);
    rdc(CTS_OFF_TBCNT_BASE, 8'h00);
    wr(CTS_OFF_TBCTL_BASE + 8'h1, 8'h06);
    wr(CTS_OFF_SEL_A, 8'h08);
    wr(CTS_OFF_CTRL_BASE + 8'h1, {4'h0, CTS_MODE_RISE});
    pl(1, 2);
    rdc(CTS_OFF_FLAG, 8'h02);
    chk({7'h0, irq}, 8'h01);
    wrc(CTS_OFF_ENABLE, 8'h00, 8'h00);
    chk({7'h0, irq}, 8'h00);
    // Oscillator period is eight clocks, so 80 clocks give ten counts
    rd(CTS_OFF_TBCNT_BASE + 8'h2);
    w = v;
    repeat (78) @(posedge ref_clk);
    rd(CTS_OFF_TBCNT_BASE + 8'h2);
    chk(v - w, 8'h0A);
    @(posedge ref_clk) sleep_mode <= 1'b0;
    rdc(CTS_OFF_TBCNT_BASE + 8'h1, 8'h80);
    rd(CTS_OFF_TBCNT_BASE);
    chk({7'h0, v > 8'h00 && v < 8'h20}, 8'h01);
    wr(CTS_OFF_TBCTL_BASE + 8'h2, 8'h05);
    wr(CTS_OFF_TBCNT_BASE + 8'h4, 8'h00);
    repeat (40) @(posedge ref_clk);
    rd(CTS_OFF_TBCNT_BASE + 8'h4);
    chk({7'h0, v >= 8'h09 && v <= 8'h0C}, 8'h01);
    $display("sleep and clock source test done");
    end_sim();
  end
endmodule
`default_nettype wire

// ### cts_pin_model.sv
// Capture pin and external clock source model
`default_nettype none
module cts_pin_model (
  input  wire logic       ref_clk,
  output var  logic [4:0] capture_pin,
  output var  logic       sosc_pin,
  output var  logic [2:0] timer_ext_clock_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] sosc_div_reg = 3'h0;
  initial capture_pin = 5'h00;
  initial timer_ext_clock_pin = 3'h0;
  // Oscillator runs free, slow enough for the synchronizer
  always @(posedge ref_clk) sosc_div_reg <= sosc_div_reg + 3'h1;
  assign sosc_pin = sosc_div_reg[2];
  // Each level held four cycles so no edge is lost; k above 4 is an ext clock
  task automatic edges(input int k, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      if (k < 5) capture_pin[k] <= ~capture_pin[k];
      else timer_ext_clock_pin[k - 5] <= ~timer_ext_clock_pin[k - 5];
      repeat (3) @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

// ### cts_pkg.sv
// Constants, register map and carrier types for the capture time-base block
// Contract
// (R01) Capture latches a 16-bit time-base count
// (R02) Time base clocks: fosc, fosc/4, sosc, pin
// (R03) Fosc-clocked time base holds during sleep
// (R04) Wake resumes count from held value
// (R05) External-clocked capture keeps working in sleep
// (R06) Unimplemented register bits read zero
// (R07) Mode picks falling, rising, 4th, 16th edge
// (R08) Event copies full count into value pair
// (R09) Capture sets flag; new capture overwrites
// (R10) Prescaler cleared off/non-capture/reset, not ratio
// (R11) Capture pin synchronized before edge detection
`default_nettype none
package cts_pkg;

  localparam int CTS_CHANNELS  = 5;
  localparam int CTS_TIMEBASES = 3;

  // Register offsets
  localparam logic [7:0] CTS_OFF_CTRL_BASE = 8'h00;  // capture_control_1..5
  localparam logic [7:0] CTS_OFF_VAL_BASE  = 8'h05;  // low, high per channel
  localparam logic [7:0] CTS_OFF_SEL_A     = 8'h0F;  // timer_select_a
  localparam logic [7:0] CTS_OFF_SEL_B     = 8'h10;  // timer_select_b
  localparam logic [7:0] CTS_OFF_PRIO      = 8'h11;  // capture_irq_priority_c
  localparam logic [7:0] CTS_OFF_ENABLE    = 8'h12;  // capture_irq_enable_c
  localparam logic [7:0] CTS_OFF_FLAG      = 8'h13;  // capture_irq_flag_c
  localparam logic [7:0] CTS_OFF_TBCTL_BASE = 8'h14; // time-base control 1..3
  localparam logic [7:0] CTS_OFF_TBCNT_BASE = 8'h17; // count low, high per base

  // Writable bits of capture_control_x; upper bits of 4 and 5 are absent
  localparam logic [7:0] CTS_CTRL_MASK_FULL  = 8'hFF;
  localparam logic [7:0] CTS_CTRL_MASK_SHORT = 8'h3F;
  localparam int         CTS_FULL_CTRL_CHANNELS = 3;

  // Field positions
  localparam int CTS_SEL_C1_LSB = 0;
  localparam int CTS_SEL_C2_LSB = 3;
  localparam int CTS_SEL_C3_LSB = 6;
  localparam int CTS_SEL_C4_LSB = 0;
  localparam int CTS_SEL_C5_LSB = 2;
  localparam int CTS_TBCTL_SRC_LSB = 0;
  localparam int CTS_TBCTL_ON_BIT  = 2;

  // Reset values
  localparam logic [7:0]  CTS_CTRL_RESET  = 8'h00;
  localparam logic [15:0] CTS_VAL_RESET   = 16'h0000;
  localparam logic [15:0] CTS_TBCNT_RESET = 16'h0000;
  localparam logic [2:0]  CTS_TBCTL_RESET = 3'h0;
  localparam logic [1:0]  CTS_TBSEL_RESET = 2'h0;

  // Capture mode field codes
  localparam logic [3:0] CTS_MODE_FALL    = 4'h4;
  localparam logic [3:0] CTS_MODE_RISE    = 4'h5;
  localparam logic [3:0] CTS_MODE_RISE4   = 4'h6;
  localparam logic [3:0] CTS_MODE_RISE16  = 4'h7;
  localparam logic [1:0] CTS_MODE_CAP_TOP = 2'h1;

  // Instruction clock divider
  localparam int         CTS_INSTR_DIV  = 4;
  localparam logic [1:0] CTS_INSTR_LAST = 2'(CTS_INSTR_DIV - 1);

  typedef enum logic [1:0] {
    CTS_SRC_FOSC  = 2'h0,
    CTS_SRC_INSTR = 2'h1,
    CTS_SRC_SOSC  = 2'h2,
    CTS_SRC_PIN   = 2'h3
  } cts_src_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cts_bus_req_type;

endpackage
`default_nettype wire
